// ### rtl/gnc_pkg.sv
package gnc_pkg;
  localparam logic [7:0] START_BYTE      = 8'h3C;
  localparam logic [7:0] END_BYTE        = 8'h3E;
  localparam logic [7:0] CMD_WRITE_NV    = 8'h23;
  localparam logic [7:0] CMD_READ_IO     = 8'h24;
  localparam logic [7:0] CMD_READ_ANALOG = 8'h26;
  localparam logic [7:0] STATUS_OK       = 8'h00;
  localparam logic [7:0] STATUS_ERR      = 8'h01;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  localparam logic [7:0] LAST_LINE       = 8'h07;

  localparam int         NV_PARAMS = 54;
  localparam int         NV_AW     = 6;
  localparam logic [5:0] NV_LAST   = 6'h35;
  localparam logic [5:0] IDX_ANALOG    = 6'h0D;
  localparam logic [5:0] IDX_DIR       = 6'h0E;
  localparam logic [5:0] IDX_PULL      = 6'h12;
  localparam logic [5:0] IDX_TRI       = 6'h13;
  localparam logic [5:0] IDX_KEY_FIRST = 6'h14;
  localparam logic [5:0] IDX_KEY_LAST  = 6'h23;
  localparam logic [5:0] IO_PARAMS     = 6'h02;

  localparam logic [7:0] NV_DEFAULT [0:53] = '{
    8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h1E, 8'h00, 8'h05, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0B, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h7E, 8'h15, 8'h16, 8'h28, 8'hAE, 8'hD2, 8'hA6, 8'hAB, 8'hAB,
    8'hF7, 8'h88, 8'h09, 8'hCF, 8'h4F, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00};

  localparam logic [3:0] RESP_LEN_SHORT = 4'h4;
  localparam logic [3:0] RESP_LEN_LONG  = 4'h8;

  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_CFG      = 8'h08;
  localparam logic [7:0] OFS_NV_INDEX = 8'h0C;
  localparam logic [7:0] OFS_NV_DATA  = 8'h10;
  localparam logic       CTRL_RESET   = 1'b1;
  localparam int         CTRL_EN_BIT  = 0;

  typedef struct packed {
    logic [7:0] analog;
    logic [7:0] dir_out;
    logic [7:0] pull_up;
    logic [7:0] pull_dn;
  } gnc_gpio_cfg_type;

  typedef struct packed {
    logic       start;
    logic [2:0] line;
  } gnc_adc_req_type;
endpackage : gnc_pkg

// ### rtl/gnc_nv_mem.sv
`timescale 1ns/100ps
module gnc_nv_mem #(
  parameter int DEPTH = 54,
  parameter int AW    = 6
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_rst,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);
  logic [7:0] mem_ff [0:DEPTH-1];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          mem_ff[gi] <= gnc_pkg::NV_DEFAULT[gi];
        end else if (i_we && (i_waddr == AW'(gi))) begin
          mem_ff[gi] <= i_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_raddr < AW'(DEPTH)) begin
      o_rdata <= mem_ff[i_raddr];
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule : gnc_nv_mem

// ### rtl/gnc_cmd_top.sv
// Behaviour
// - Analog byte: bit n selects analog line n.
// - Direction byte: bit 1 output, 0 input.
// - Analog lines act only as inputs.
// - Pull byte zero pulls up, else down.
// - Tri-state bit overrides the pull choice.
// - Tri-state bit 1 removes both resistors.
// - Sixteen parameters form the 128-bit key.
// - Read status byte: 00 good, 01 error.
// - Write frame 3C 23 params 3E, short answer.
// - New values readable now, used after reset; here reset reloads NV_DEFAULT into storage, so they are lost.
// - Working copies loaded from storage at start.
// - Line query 3C 24 00 line 3E, working values.
// - Line answer: zero, line, analog, direction, status.
// - Line answer status 00 good, 01 error.
// - Analog read 3C 26 00 line 3E.
// - Two conversion bytes: high*16 plus low.
// - Analog status 00 good, 01 error.
`timescale 1ns/100ps
module gnc_cmd_top #(
  parameter int ADC_W = 12
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [7:0]                i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic      [31:0]               o_prdata,
  output logic                           o_pready,
  output logic                           o_pslverr,
  input  wire logic                      i_rx_valid,
  input  wire logic [7:0]                i_rx_byte,
  output logic                           o_rx_ready,
  output logic                           o_tx_valid,
  output logic      [7:0]                o_tx_byte,
  input  wire logic                      i_tx_ready,
  output gnc_pkg::gnc_adc_req_type       o_adc_req,
  input  wire logic                      i_adc_done,
  input  wire logic [ADC_W-1:0]          i_adc_value,
  output gnc_pkg::gnc_gpio_cfg_type      o_gpio_cfg,
  output logic      [127:0]              o_aes_key,
  output logic                           o_init_done
);
  typedef enum {ST_INIT, ST_IDLE, ST_CMD, ST_PARAM, ST_END, ST_ADC, ST_TX} gnc_state_type;

  gnc_state_type state_ff;
  logic [5:0]    cnt_ff;
  logic [7:0]    cmd_ff;
  logic [7:0]    p1_ff;
  logic [7:0]    line_ff;
  logic [7:0]    analog_ff;
  logic [7:0]    dir_ff;
  logic [7:0]    pull_ff;
  logic [7:0]    tri_ff;
  logic [127:0]  key_ff;
  logic          init_done_ff;
  logic [7:0]    resp_ff [0:7];
  logic [3:0]    resp_left_ff;
  logic          err_ff;
  logic          en_ff;
  logic          adc_start_ff;
  logic [5:0]    nv_index_ff;
  logic [7:0]    nv_rdata;
  logic          rx_take;
  logic          tx_take;
  logic          end_ok;
  logic          line_bad;
  logic          nv_we;
  logic [5:0]    init_idx;
  logic          apb_setup;
  logic          apb_wr;
  logic          mapped;

  assign rx_take  = i_rx_valid && o_rx_ready;
  assign tx_take  = o_tx_valid && i_tx_ready;
  assign end_ok   = (i_rx_byte == gnc_pkg::END_BYTE);
  assign line_bad = (line_ff > gnc_pkg::LAST_LINE) || (p1_ff != gnc_pkg::ZERO_BYTE);
  assign nv_we    = rx_take && (state_ff == ST_PARAM) && (cmd_ff == gnc_pkg::CMD_WRITE_NV);
  assign init_idx = cnt_ff - 6'h01;

  gnc_nv_mem #(
    .DEPTH (gnc_pkg::NV_PARAMS),
    .AW    (gnc_pkg::NV_AW)
  ) u_nv_mem (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_we      (nv_we),
    .i_waddr   (cnt_ff),
    .i_wdata   (i_rx_byte),
    .i_raddr   ((state_ff == ST_INIT) ? cnt_ff : nv_index_ff),
    .o_rdata   (nv_rdata)
  );

  // Only the frame states take bytes; replies, conversions and start-up stall the link.
  assign o_rx_ready = en_ff && ((state_ff == ST_IDLE) || (state_ff == ST_CMD) ||
                                (state_ff == ST_PARAM) || (state_ff == ST_END));
  assign o_tx_valid = (state_ff == ST_TX);
  assign o_tx_byte  = resp_ff[0];
  assign o_init_done = init_done_ff;
  assign o_aes_key   = key_ff;
  assign o_adc_req   = '{start: adc_start_ff, line: line_ff[2:0]};

  always_comb begin
    o_gpio_cfg.analog  = analog_ff;
    o_gpio_cfg.dir_out = dir_ff & ~analog_ff;
    o_gpio_cfg.pull_up = (pull_ff == 8'h00) ? ~tri_ff : 8'h00;
    o_gpio_cfg.pull_dn = (pull_ff != 8'h00) ? ~tri_ff : 8'h00;
  end

  // Start-up walk copies the stored parameters into the working copies.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      analog_ff <= 8'h00;
      dir_ff    <= 8'h00;
      pull_ff   <= 8'h00;
      tri_ff    <= 8'h00;
      key_ff    <= 128'h0;
    end else if ((state_ff == ST_INIT) && (cnt_ff != 6'h00)) begin
      if (init_idx == gnc_pkg::IDX_ANALOG) begin
        analog_ff <= nv_rdata;
      end
      if (init_idx == gnc_pkg::IDX_DIR) begin
        dir_ff <= nv_rdata;
      end
      if (init_idx == gnc_pkg::IDX_PULL) begin
        pull_ff <= nv_rdata;
      end
      if (init_idx == gnc_pkg::IDX_TRI) begin
        tri_ff <= nv_rdata;
      end
      if ((init_idx >= gnc_pkg::IDX_KEY_FIRST) && (init_idx <= gnc_pkg::IDX_KEY_LAST)) begin
        key_ff <= {key_ff[119:0], nv_rdata};
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      init_done_ff <= 1'b0;
    end else if ((state_ff == ST_INIT) && (cnt_ff == 6'(gnc_pkg::NV_PARAMS))) begin
      init_done_ff <= 1'b1;
    end
  end

  // Frame parser and sequencer.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ST_INIT;
      cnt_ff   <= 6'h00;
      cmd_ff   <= 8'h00;
      p1_ff    <= 8'h00;
      line_ff  <= 8'h00;
    end else begin
      case (state_ff)
        ST_INIT: begin
          cnt_ff <= cnt_ff + 6'h01;
          if (cnt_ff == 6'(gnc_pkg::NV_PARAMS)) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (rx_take && (i_rx_byte == gnc_pkg::START_BYTE)) begin
            state_ff <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (rx_take) begin
            cmd_ff <= i_rx_byte;
            cnt_ff <= 6'h00;
            if ((i_rx_byte == gnc_pkg::CMD_WRITE_NV) || (i_rx_byte == gnc_pkg::CMD_READ_IO) ||
                (i_rx_byte == gnc_pkg::CMD_READ_ANALOG)) begin
              state_ff <= ST_PARAM;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_PARAM: begin
          if (rx_take) begin
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff == 6'h00) begin
              p1_ff <= i_rx_byte;
            end
            if (cnt_ff == 6'h01) begin
              line_ff <= i_rx_byte;
            end
            if (((cmd_ff == gnc_pkg::CMD_WRITE_NV) && (cnt_ff == gnc_pkg::NV_LAST)) ||
                ((cmd_ff != gnc_pkg::CMD_WRITE_NV) && (cnt_ff == gnc_pkg::IO_PARAMS - 6'h01))) begin
              state_ff <= ST_END;
            end
          end
        end
        ST_END: begin
          if (rx_take) begin
            if ((cmd_ff == gnc_pkg::CMD_READ_ANALOG) && end_ok && !line_bad &&
                analog_ff[line_ff[2:0]]) begin
              state_ff <= ST_ADC;
            end else begin
              state_ff <= ST_TX;
            end
          end
        end
        ST_ADC: begin
          if (i_adc_done) begin
            state_ff <= ST_TX;
          end
        end
        ST_TX: begin
          if (tx_take && (resp_left_ff == 4'h1)) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      adc_start_ff <= 1'b0;
    end else begin
      adc_start_ff <= rx_take && (state_ff == ST_END) && (cmd_ff == gnc_pkg::CMD_READ_ANALOG) &&
                      end_ok && !line_bad && analog_ff[line_ff[2:0]];
    end
  end

  // Answer buffer: built whole, then shifted out one byte per handshake.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 8; i++) begin
        resp_ff[i] <= 8'h00;
      end
      resp_left_ff <= 4'h0;
      err_ff       <= 1'b0;
    end else if (rx_take && (state_ff == ST_END)) begin
      resp_ff[0] <= gnc_pkg::START_BYTE;
      resp_ff[1] <= cmd_ff;
      if (cmd_ff == gnc_pkg::CMD_WRITE_NV) begin
        resp_ff[2]   <= end_ok ? gnc_pkg::STATUS_OK : gnc_pkg::STATUS_ERR;
        resp_ff[3]   <= gnc_pkg::END_BYTE;
        resp_left_ff <= gnc_pkg::RESP_LEN_SHORT;
        err_ff       <= !end_ok;
      end else begin
        resp_ff[2] <= gnc_pkg::ZERO_BYTE;
        resp_ff[3] <= line_ff;
        resp_ff[4] <= {7'h00, analog_ff[line_ff[2:0]] & !line_bad};
        resp_ff[5] <= {7'h00, dir_ff[line_ff[2:0]] & !line_bad};
        resp_ff[7] <= gnc_pkg::END_BYTE;
        resp_left_ff <= gnc_pkg::RESP_LEN_LONG;
        if ((cmd_ff == gnc_pkg::CMD_READ_IO) && end_ok && !line_bad) begin
          resp_ff[6] <= gnc_pkg::STATUS_OK;
          err_ff     <= 1'b0;
        end else begin
          resp_ff[6] <= gnc_pkg::STATUS_ERR;
          err_ff     <= 1'b1;
        end
        if (cmd_ff == gnc_pkg::CMD_READ_ANALOG) begin
          resp_ff[4] <= gnc_pkg::ZERO_BYTE;
          resp_ff[5] <= gnc_pkg::ZERO_BYTE;
        end
      end
    end else if ((state_ff == ST_ADC) && i_adc_done) begin
      resp_ff[4] <= i_adc_value[ADC_W-1 -: 8];
      resp_ff[5] <= {4'h0, i_adc_value[3:0]};
      resp_ff[6] <= gnc_pkg::STATUS_OK;
      err_ff     <= 1'b0;
    end else if (tx_take) begin
      for (int i = 0; i < 7; i++) begin
        resp_ff[i] <= resp_ff[i+1];
      end
      resp_ff[7]   <= 8'h00;
      resp_left_ff <= resp_left_ff - 4'h1;
    end
  end

  // APB slave with zero wait states; read data is captured in the setup cycle.
  assign apb_setup = i_psel && !i_penable;
  assign apb_wr    = i_psel && i_penable && i_pwrite;
  assign mapped    = (i_paddr == gnc_pkg::OFS_CTRL) || (i_paddr == gnc_pkg::OFS_STATUS) ||
                     (i_paddr == gnc_pkg::OFS_CFG) || (i_paddr == gnc_pkg::OFS_NV_INDEX) ||
                     (i_paddr == gnc_pkg::OFS_NV_DATA);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      en_ff       <= gnc_pkg::CTRL_RESET;
      nv_index_ff <= 6'h00;
    end else if (apb_wr && (i_paddr == gnc_pkg::OFS_CTRL)) begin
      en_ff <= i_pwdata[gnc_pkg::CTRL_EN_BIT];
    end else if (apb_wr && (i_paddr == gnc_pkg::OFS_NV_INDEX)) begin
      nv_index_ff <= i_pwdata[5:0];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0;
    end else if (apb_setup) begin
      case (i_paddr)
        gnc_pkg::OFS_CTRL:     o_prdata <= {31'h0, en_ff};
        gnc_pkg::OFS_STATUS:   o_prdata <= {29'h0, err_ff, (state_ff != ST_IDLE), init_done_ff};
        gnc_pkg::OFS_CFG:      o_prdata <= {tri_ff, pull_ff, dir_ff, analog_ff};
        gnc_pkg::OFS_NV_INDEX: o_prdata <= {26'h0, nv_index_ff};
        gnc_pkg::OFS_NV_DATA:  o_prdata <= {24'h0, nv_rdata};
        default:               o_prdata <= 32'h0;
      endcase
    end
  end

  property p_analog_input;
    @(posedge i_sys_clk) disable iff (i_rst)
    (o_gpio_cfg.dir_out & o_gpio_cfg.analog) == 8'h00;
  endproperty
  a_analog_input: assert property (p_analog_input) else $error("Analog line driven out.");

  property p_tri_no_pull;
    @(posedge i_sys_clk) disable iff (i_rst)
    ((o_gpio_cfg.pull_up | o_gpio_cfg.pull_dn) & tri_ff) == 8'h00;
  endproperty
  a_tri_no_pull: assert property (p_tri_no_pull) else $error("Pull on tri-state line.");

  property p_pull_choice;
    @(posedge i_sys_clk) disable iff (i_rst)
    (pull_ff == 8'h00) |-> (o_gpio_cfg.pull_up == ~tri_ff) && (o_gpio_cfg.pull_dn == 8'h00);
  endproperty
  a_pull_choice: assert property (p_pull_choice) else $error("Wrong pull selection.");

  property p_working_stable;
    @(posedge i_sys_clk) disable iff (i_rst)
    $past(init_done_ff) |-> $stable(analog_ff) && $stable(dir_ff) && $stable(key_ff);
  endproperty
  a_working_stable: assert property (p_working_stable) else $error("Working copy changed.");

  sequence s_reply_begins;
    (state_ff != ST_TX) ##1 (state_ff == ST_TX);
  endsequence
  property p_reply_framed;
    @(posedge i_sys_clk) disable iff (i_rst)
    s_reply_begins |-> (o_tx_byte == gnc_pkg::START_BYTE) && (resp_ff[1] == cmd_ff);
  endproperty
  a_reply_framed: assert property (p_reply_framed) else $error("Reply start wrong.");

  property p_reply_end;
    @(posedge i_sys_clk) disable iff (i_rst)
    tx_take && (resp_left_ff == 4'h1) |-> (o_tx_byte == gnc_pkg::END_BYTE) ##1 (state_ff == ST_IDLE);
  endproperty
  a_reply_end: assert property (p_reply_end) else $error("Reply end wrong.");

  sequence s_bad_analog;
    rx_take && (state_ff == ST_END) && (cmd_ff == gnc_pkg::CMD_READ_ANALOG) &&
    (line_bad || !analog_ff[line_ff[2:0]]);
  endsequence
  property p_bad_analog;
    @(posedge i_sys_clk) disable iff (i_rst)
    s_bad_analog |=> (state_ff == ST_TX) && (resp_ff[6] == gnc_pkg::STATUS_ERR) && !o_adc_req.start;
  endproperty
  a_bad_analog: assert property (p_bad_analog) else $error("Bad analog read not refused.");

  property p_adc_bytes;
    @(posedge i_sys_clk) disable iff (i_rst)
    (state_ff == ST_ADC) && i_adc_done |=>
      ({resp_ff[4], resp_ff[5][3:0]} == $past(i_adc_value)) && (resp_ff[6] == gnc_pkg::STATUS_OK);
  endproperty
  a_adc_bytes: assert property (p_adc_bytes) else $error("Conversion bytes wrong.");

  property p_io_answer;
    @(posedge i_sys_clk) disable iff (i_rst)
    rx_take && (state_ff == ST_END) && (cmd_ff == gnc_pkg::CMD_READ_IO) && !line_bad |=>
      (resp_ff[4][0] == analog_ff[line_ff[2:0]]) && (resp_ff[5][0] == dir_ff[line_ff[2:0]]) &&
      (resp_ff[3] == line_ff);
  endproperty
  a_io_answer: assert property (p_io_answer) else $error("Line answer wrong.");

  property p_nv_write_range;
    @(posedge i_sys_clk) disable iff (i_rst)
    nv_we |-> (cnt_ff <= gnc_pkg::NV_LAST);
  endproperty
  a_nv_write_range: assert property (p_nv_write_range) else $error("Write past table.");
endmodule : gnc_cmd_top

// ### testbench/gnc_host_model.sv
`timescale 1ns/100ps
module gnc_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rx_ready,
  output logic            o_rx_valid,
  output logic      [7:0] o_rx_byte,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_tx_ready
);
  logic [7:0] reply_q [$];
  logic       slow;
  logic       tick_ff;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_byte  = 8'h00;
    o_tx_ready = 1'b0;
    slow       = 1'b0;
    tick_ff    = 1'b0;
  end

  // Sends a whole frame, each byte held until the device takes it.
  task automatic send(input logic [7:0] f [$]);
    foreach (f[i]) begin
      o_rx_valid <= 1'b1;
      o_rx_byte  <= f[i];
      @(posedge i_sys_clk);
      while (i_rx_ready !== 1'b1) @(posedge i_sys_clk);
    end
    o_rx_valid <= 1'b0;
    o_rx_byte  <= ~f[f.size()-1];
  endtask : send

  // Collects reply bytes and stalls every other cycle in slow mode.
  always @(posedge i_sys_clk) begin
    if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) reply_q.push_back(i_tx_byte);
    tick_ff    <= ~tick_ff;
    o_tx_ready <= slow ? tick_ff : 1'b1;
  end
endmodule : gnc_host_model

// ### testbench/gnc_cmd_top_tb.sv
`timescale 1ns/100ps
module gnc_cmd_top_tb;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        err;
  } gnc_row_type;
  logic                      i_sys_clk, i_rst, i_psel, i_penable, i_pwrite;
  logic [7:0]                i_paddr;
  logic [31:0]               i_pwdata, o_prdata;
  logic                      o_pready, o_pslverr, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0]                rx_byte, tx_byte;
  gnc_pkg::gnc_adc_req_type  o_adc_req;
  gnc_pkg::gnc_gpio_cfg_type o_gpio_cfg;
  logic [127:0]              o_aes_key, exp_key;
  logic                      o_init_done, err;
  logic [31:0]               rd;
  logic [7:0]                f [$];
  int                        fail_count, tests_run, cycles, adc_starts, n;
  gnc_row_type rows [0:7] = '{
    '{1'b0, gnc_pkg::OFS_CTRL, 32'h0, 32'h1, 1'b0},
    '{1'b0, gnc_pkg::OFS_STATUS, 32'h0, 32'h1, 1'b0},
    '{1'b0, gnc_pkg::OFS_CFG, 32'h0, 32'h0, 1'b0},
    '{1'b1, gnc_pkg::OFS_NV_INDEX, 32'h15, 32'h0, 1'b0},
    '{1'b0, gnc_pkg::OFS_NV_INDEX, 32'h0, 32'h15, 1'b0},
    '{1'b0, gnc_pkg::OFS_NV_DATA, 32'h0, 32'h7E, 1'b0},
    '{1'b0, 8'h40, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h40, 32'h5, 32'h0, 1'b1}};

  gnc_cmd_top dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .o_rx_ready(rx_ready),
    .o_tx_valid(tx_valid), .o_tx_byte(tx_byte), .i_tx_ready(tx_ready),
    .o_adc_req(o_adc_req), .i_adc_done(1'b0), .i_adc_value(12'h000),
    .o_gpio_cfg(o_gpio_cfg), .o_aes_key(o_aes_key), .o_init_done(o_init_done));
  gnc_host_model host (.i_sys_clk(i_sys_clk), .i_rx_ready(rx_ready), .o_rx_valid(rx_valid),
    .o_rx_byte(rx_byte), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte), .o_tx_ready(tx_ready));

  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (o_adc_req.start === 1'b1) adc_starts <= adc_starts + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      end_of_test();
    end
  end

  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= wd;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 50);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask : apb

  task automatic run_cmd(input logic [7:0] cmd [$], input logic [7:0] exp [$]);
    int k;
    host.reply_q.delete();
    host.send(cmd);
    k = 0;
    while (host.reply_q.size() < exp.size() && k < 400) begin
      @(posedge i_sys_clk);
      k++;
    end
    repeat (3) @(posedge i_sys_clk);
    check("reply_len", host.reply_q.size(), exp.size());
    foreach (exp[i]) check("reply_byte", host.reply_q[i], exp[i]);
  endtask : run_cmd

  task automatic do_reset();
    i_rst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    check("init_in_reset", {rx_ready, o_init_done}, 2'b00);
    i_rst <= 1'b0;
    n = 0;
    while (o_init_done !== 1'b1 && n < 200) begin
      @(posedge i_sys_clk);
      n++;
    end
    check("init_wait", n > 50, 1'b1);
    exp_key = '0;
    for (int k = 0; k < 16; k++) exp_key = {exp_key[119:0], gnc_pkg::NV_DEFAULT[20+k]};
    check("aes_key", o_aes_key, exp_key);
    check("gpio_cfg", o_gpio_cfg, 32'h0000FF00);
  endtask : do_reset

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    i_rst = 1'b1;
    {fail_count, tests_run, cycles, adc_starts} = '0;
    do_reset();
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata);
      check("apb_err", err, rows[i].err);
      if (!rows[i].wr) check("apb_rd", rd, rows[i].rdata);
    end
    apb(1'b1, gnc_pkg::OFS_CTRL, 32'h0);
    check("rx_stall", rx_ready, 1'b0);
    apb(1'b1, gnc_pkg::OFS_CTRL, 32'h1);
    for (int k = 0; k < 9; k++)
      run_cmd('{8'h3C, 8'h24, 8'h00, 8'(k), 8'h3E},
              '{8'h3C, 8'h24, 8'h00, 8'(k), 8'h00, 8'h00, (k > 7) ? 8'h01 : 8'h00, 8'h3E});
    apb(1'b0, gnc_pkg::OFS_STATUS, 32'h0);
    check("status_err", rd, 32'h5);
    run_cmd('{8'h3C, 8'h24, 8'h01, 8'h03, 8'h3E}, '{8'h3C, 8'h24, 8'h00, 8'h03, 8'h00, 8'h00, 8'h01, 8'h3E});
    run_cmd('{8'h3C, 8'h24, 8'h00, 8'h03, 8'h3F}, '{8'h3C, 8'h24, 8'h00, 8'h03, 8'h00, 8'h00, 8'h01, 8'h3E});
    run_cmd('{8'h3C, 8'h26, 8'h00, 8'h02, 8'h3E}, '{8'h3C, 8'h26, 8'h00, 8'h02, 8'h00, 8'h00, 8'h01, 8'h3E});
    run_cmd('{8'h3C, 8'h26, 8'h00, 8'h09, 8'h3E}, '{8'h3C, 8'h26, 8'h00, 8'h09, 8'h00, 8'h00, 8'h01, 8'h3E});
    check("adc_starts", adc_starts, 0);
    host.slow = 1'b1;
    f = '{8'h3C, 8'h23};
    for (int k = 0; k < 54; k++) f.push_back((k == 13) ? 8'hFF : (k == 14) ? 8'h0F : 8'(k));
    f.push_back(8'h3E);
    run_cmd(f, '{8'h3C, 8'h23, 8'h00, 8'h3E});
    apb(1'b1, gnc_pkg::OFS_NV_INDEX, 32'h0D);
    apb(1'b0, gnc_pkg::OFS_NV_DATA, 32'h0);
    check("nv_readback", rd, 32'hFF);
    check("cfg_unchanged", o_gpio_cfg, 32'h0000FF00);
    run_cmd('{8'h3C, 8'h24, 8'h00, 8'h00, 8'h3E}, '{8'h3C, 8'h24, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3E});
    f[56] = 8'h3F;
    run_cmd(f, '{8'h3C, 8'h23, 8'h01, 8'h3E});
    host.slow = 1'b0;
    do_reset();
    end_of_test();
  end
endmodule : gnc_cmd_top_tb
